// *** common/uad_defines.vh ***
// constants and behaviour summary for the alpha field decoder
// Behaviour
// - leading byte 0x80 means each following byte pair up to an all-ones pair is one 16-bit character
// - in the pair scheme the earlier byte is the high byte
// - with leading byte 0x81, byte two is the character count
// - 0x81 base pointer is byte three placed at bits 14..7, rest zero
// - 0x81 characters start at byte four; top bit clear gives a default character
// - top bit set: low seven bits plus base pointer is the code point
// - with leading byte 0x82, byte two is the count, bytes three-four the base
// - 0x82 characters start at byte five under the same top-bit rule
// - inside the declared count a 0xff byte is a character, not padding
// - all three wide schemes are decoded, covering small and large sets
`ifndef UAD_DEFINES_VH
`define UAD_DEFINES_VH

`define UAD_BYTE_W       8
`define UAD_CHAR_W       16
`define UAD_CNT_W        8
`define UAD_TOP_BIT      7
`define UAD_LOW7         6:0

`define UAD_LEAD_PAIR    8'h80
`define UAD_LEAD_HALF    8'h81
`define UAD_LEAD_FULL    8'h82
`define UAD_PAD_BYTE     8'hff
`define UAD_PAD_PAIR     16'hffff

`define UAD_HALF_TOP     1'h0
`define UAD_HALF_LOW     7'h00
`define UAD_DEF_HIGH     9'h000

`define UAD_SCH_DEFAULT  2'h0
`define UAD_SCH_PAIR     2'h1
`define UAD_SCH_HALF     2'h2
`define UAD_SCH_FULL     2'h3

`define UAD_CNT_ZERO     8'h00
`define UAD_CNT_ONE      8'h01

`endif

// *** verilog/uad_base_add.v ***
// adds a seven-bit offset to a sixteen-bit base pointer
`timescale 1ns/1ps
`include "uad_defines.vh"

module uad_base_add #(
	parameter W = `UAD_CHAR_W
) (
	input  wire [W-1:0] base,
	input  wire [6:0]   offset,
	output wire [W-1:0] sum
);

	// wraps inside the code space, no carry out
	assign sum = base + {{(W-7){1'b0}}, offset};

endmodule // uad_base_add

// *** verilog/uad_down_counter.v ***
// loadable down counter for the declared character count
`timescale 1ns/1ps
`include "uad_defines.vh"

module uad_down_counter #(
	parameter W = `UAD_CNT_W
) (
	input  wire         clk,
	input  wire         resetn,
	input  wire         load,
	input  wire [W-1:0] load_val,
	input  wire         dec,
	output wire         is_zero,
	output wire         is_one
);

	reg [W-1:0] count;

	always @(posedge clk) begin
		if (!resetn) begin
			count <= {W{1'b0}};
		end else if (load) begin
			count <= load_val;
		end else if (dec && (count != {W{1'b0}})) begin
			count <= count - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign is_zero = (count == {W{1'b0}});
	assign is_one  = (count == {{(W-1){1'b0}}, 1'b1});

endmodule // uad_down_counter

// *** verilog/uad_decoder.v ***
// alpha field byte stream to character stream decoder
`timescale 1ns/1ps
`include "uad_defines.vh"

module uad_decoder (
	input  wire        clk,
	input  wire        resetn,
	input  wire        in_valid,
	output wire        in_ready,
	input  wire [7:0]  in_byte,
	input  wire        in_last,
	output reg         out_valid,
	input  wire        out_ready,
	output reg  [15:0] out_char,
	output reg         out_ucs2,
	output reg  [1:0]  scheme,
	output reg         rec_done,
	output reg         short_rec
);

	localparam [8:0] ST_HEAD    = 9'h001;
	localparam [8:0] ST_PAIR_HI = 9'h002;
	localparam [8:0] ST_PAIR_LO = 9'h004;
	localparam [8:0] ST_COUNT   = 9'h008;
	localparam [8:0] ST_BASE_HI = 9'h010;
	localparam [8:0] ST_BASE_LO = 9'h020;
	localparam [8:0] ST_CHARS   = 9'h040;
	localparam [8:0] ST_DEFAULT = 9'h080;
	localparam [8:0] ST_SKIP    = 9'h100;

	reg  [8:0]  state;
	reg  [7:0]  hi_byte;
	reg  [15:0] base;

	reg  [8:0]  next_state;
	reg  [7:0]  next_hi_byte;
	reg  [15:0] next_base;
	reg         next_out_valid;
	reg  [15:0] next_out_char;
	reg         next_out_ucs2;
	reg  [1:0]  next_scheme;
	reg         next_rec_done;
	reg         next_short_rec;
	reg         cnt_load;
	reg         cnt_dec;

	wire        take;
	wire        cnt_zero;
	wire        cnt_one;
	wire [15:0] offset_sum;
	wire        top_set;
	wire [15:0] default_char;

	// one output stage; a byte is taken only when the stage can accept a result
	assign in_ready     = ~out_valid | out_ready;
	assign take         = in_valid & in_ready;
	assign top_set      = in_byte[`UAD_TOP_BIT];
	assign default_char = {`UAD_DEF_HIGH, in_byte[`UAD_LOW7]};

	uad_base_add #(
		.W(`UAD_CHAR_W)
	) u_add (
		.base  (base),
		.offset(in_byte[`UAD_LOW7]),
		.sum   (offset_sum)
	);

	uad_down_counter #(
		.W(`UAD_CNT_W)
	) u_cnt (
		.clk     (clk),
		.resetn  (resetn),
		.load    (cnt_load),
		.load_val(in_byte),
		.dec     (cnt_dec),
		.is_zero (cnt_zero),
		.is_one  (cnt_one)
	);

	always @* begin
		next_state     = state;
		next_hi_byte   = hi_byte;
		next_base      = base;
		next_out_valid = out_valid & ~out_ready;
		next_out_char  = out_char;
		next_out_ucs2  = out_ucs2;
		next_scheme    = scheme;
		next_rec_done  = 1'b0;
		next_short_rec = 1'b0;
		cnt_load       = 1'b0;
		cnt_dec        = 1'b0;
		if (take) begin
			case (state)
				ST_HEAD: begin
					// all three wide schemes are always available
					if (in_byte == `UAD_LEAD_PAIR) begin
						next_scheme = `UAD_SCH_PAIR;
						next_state  = ST_PAIR_HI;
					end else if (in_byte == `UAD_LEAD_HALF) begin
						next_scheme = `UAD_SCH_HALF;
						next_state  = ST_COUNT;
					end else if (in_byte == `UAD_LEAD_FULL) begin
						next_scheme = `UAD_SCH_FULL;
						next_state  = ST_COUNT;
					end else if (in_byte == `UAD_PAD_BYTE) begin
						// empty default record
						next_scheme = `UAD_SCH_DEFAULT;
						next_state  = ST_SKIP;
					end else begin
						next_scheme    = `UAD_SCH_DEFAULT;
						next_out_valid = 1'b1;
						next_out_char  = default_char;
						next_out_ucs2  = 1'b0;
						next_state     = ST_DEFAULT;
					end
				end
				ST_PAIR_HI: begin
					next_hi_byte = in_byte;
					next_state   = ST_PAIR_LO;
				end
				ST_PAIR_LO: begin
					// an all-ones pair is padding and ends the text
					if ({hi_byte, in_byte} == `UAD_PAD_PAIR) begin
						next_state = ST_SKIP;
					end else begin
						next_out_valid = 1'b1;
						next_out_char  = {hi_byte, in_byte};
						next_out_ucs2  = 1'b1;
						next_state     = ST_PAIR_HI;
					end
				end
				ST_COUNT: begin
					cnt_load = 1'b1;
					if (scheme == `UAD_SCH_HALF) begin
						next_state = ST_BASE_LO;
					end else begin
						next_state = ST_BASE_HI;
					end
				end
				ST_BASE_HI: begin
					next_hi_byte = in_byte;
					next_state   = ST_BASE_LO;
				end
				ST_BASE_LO: begin
					if (scheme == `UAD_SCH_HALF) begin
						next_base = {`UAD_HALF_TOP, in_byte, `UAD_HALF_LOW};
					end else begin
						next_base = {hi_byte, in_byte};
					end
					// characters follow at byte four or five
					if (cnt_zero) begin
						next_state = ST_SKIP;
					end else begin
						next_state = ST_CHARS;
					end
				end
				ST_CHARS: begin
					// every byte inside the count is a character, 0xff included
					next_out_valid = 1'b1;
					cnt_dec        = 1'b1;
					if (top_set) begin
						next_out_char = offset_sum;
						next_out_ucs2 = 1'b1;
					end else begin
						next_out_char = default_char;
						next_out_ucs2 = 1'b0;
					end
					if (cnt_one) begin
						next_state = ST_SKIP;
					end
				end
				ST_DEFAULT: begin
					if (in_byte == `UAD_PAD_BYTE) begin
						next_state = ST_SKIP;
					end else begin
						next_out_valid = 1'b1;
						next_out_char  = default_char;
						next_out_ucs2  = 1'b0;
					end
				end
				ST_SKIP: begin
					next_state = ST_SKIP;
				end
				default: begin
					next_state = ST_SKIP;
				end
			endcase
			if (in_last) begin
				next_state    = ST_HEAD;
				next_rec_done = 1'b1;
				// record ended inside the header or before the declared count was delivered
				if (((state == ST_HEAD) && ((in_byte == `UAD_LEAD_HALF) ||
				                            (in_byte == `UAD_LEAD_FULL))) ||
				    (state == ST_COUNT) || (state == ST_BASE_HI) ||
				    ((state == ST_BASE_LO) && !cnt_zero) ||
				    ((state == ST_CHARS) && !cnt_one)) begin
					next_short_rec = 1'b1;
				end
			end
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			state     <= ST_HEAD;
			hi_byte   <= 8'h00;
			base      <= 16'h0000;
			out_valid <= 1'b0;
			out_char  <= 16'h0000;
			out_ucs2  <= 1'b0;
			scheme    <= `UAD_SCH_DEFAULT;
			rec_done  <= 1'b0;
			short_rec <= 1'b0;
		end else begin
			state     <= next_state;
			hi_byte   <= next_hi_byte;
			base      <= next_base;
			out_valid <= next_out_valid;
			out_char  <= next_out_char;
			out_ucs2  <= next_out_ucs2;
			scheme    <= next_scheme;
			rec_done  <= next_rec_done;
			short_rec <= next_short_rec;
		end
	end

endmodule // uad_decoder

// *** verification/uad_props.sv ***
// protocol checks on the alpha field decoder ports
`timescale 1ns/1ps
`include "uad_defines.vh"
module uad_props (
	input wire        clk,
	input wire        resetn,
	input wire        in_valid,
	input wire        in_ready,
	input wire [7:0]  in_byte,
	input wire        in_last,
	input wire        out_valid,
	input wire        out_ready,
	input wire [15:0] out_char,
	input wire        out_ucs2,
	input wire [1:0]  scheme,
	input wire        rec_done,
	input wire        short_rec
);
	reg  first;
	wire take = in_valid && in_ready;
	wire hdr  = in_byte == `UAD_LEAD_PAIR || in_byte == `UAD_LEAD_HALF ||
		in_byte == `UAD_LEAD_FULL;
	// next byte taken is byte one
	always @(posedge clk) begin
		if (!resetn)
			first <= 1'b1;
		else if (take)
			first <= in_last;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_ready_comb: assert property (in_ready == (!out_valid || out_ready))
		else $error("in_ready does not follow the output handshake");
	a_char_hold: assert property (out_valid && !out_ready |=>
		out_valid && $stable(out_char) && $stable(out_ucs2))
		else $error("character changed while stalled");
	a_done_cause: assert property (take && in_last |=> rec_done)
		else $error("no record end after last byte");
	a_done_only: assert property (rec_done |-> $past(take && in_last))
		else $error("record end without last byte");
	a_short_done: assert property (short_rec |-> rec_done)
		else $error("short flag outside record end");
	a_scheme_pick: assert property (take && first |=> scheme ==
		($past(in_byte) == `UAD_LEAD_PAIR ? 2'h1 : $past(in_byte) == `UAD_LEAD_HALF ? 2'h2 :
		$past(in_byte) == `UAD_LEAD_FULL ? 2'h3 : 2'h0))
		else $error("scheme not taken from byte one");
	a_header_quiet: assert property (take && first && hdr |=> !out_valid)
		else $error("header byte produced a character");
	a_default_char: assert property (take && first && !in_byte[7] |=>
		out_valid && !out_ucs2 && out_char == {9'h000, $past(in_byte[6:0])})
		else $error("default byte one not passed on");
	a_head_short: assert property (take && first && in_last &&
		(in_byte == `UAD_LEAD_HALF || in_byte == `UAD_LEAD_FULL) |=> short_rec)
		else $error("count record of byte one only not flagged short");
	a_valid_cause: assert property ($rose(out_valid) |-> $past(take))
		else $error("character without a byte taken");
endmodule // uad_props
bind uad_decoder uad_props uad_props_i (.clk(clk), .resetn(resetn), .in_valid(in_valid),
	.in_ready(in_ready), .in_byte(in_byte), .in_last(in_last), .out_valid(out_valid),
	.out_ready(out_ready), .out_char(out_char), .out_ucs2(out_ucs2), .scheme(scheme),
	.rec_done(rec_done), .short_rec(short_rec));

// *** verification/uad_sink.sv ***
// consumer of decoded characters, prompt or stalling
`timescale 1ns/1ps
module uad_sink (
	input wire clk,
	input wire slow,
	output reg out_ready
);
	integer seed = 23;
	initial out_ready = 1'b0;
	always @(posedge clk) begin
		out_ready <= slow ? ($random(seed) % 4 == 0) : ($random(seed) % 8 != 0);
	end
endmodule // uad_sink

// *** verification/tb.sv ***
// self-checking bench for the alpha field decoder
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
	reg         clk = 1'b0, resetn = 1'b0, in_valid = 1'b0, in_last = 1'b0, slow = 1'b0;
	reg  [7:0]  in_byte = 8'h00;
	wire        in_ready, out_valid, out_ready, out_ucs2, rec_done, short_rec;
	wire [15:0] out_char;
	wire [1:0]  scheme;
	integer     seed = 23, n_mismatch = 0, samples_checked = 0, i, j, k, t, w;
	reg  [7:0]  q[$];
	reg  [16:0] exp[$];
	reg         exp_short;
	reg  [16:0] want;
	reg  [15:0] base;
	always #4 clk = ~clk;
	uad_decoder uad_decoder_i (.clk(clk), .resetn(resetn), .in_valid(in_valid),
		.in_ready(in_ready), .in_byte(in_byte), .in_last(in_last), .out_valid(out_valid),
		.out_ready(out_ready), .out_char(out_char), .out_ucs2(out_ucs2), .scheme(scheme),
		.rec_done(rec_done), .short_rec(short_rec));
	uad_sink uad_sink_i (.clk(clk), .slow(slow), .out_ready(out_ready));
	task results;
		begin
			if (n_mismatch == 0 && samples_checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task predict;
		begin
			exp.delete();
			exp_short = 1'b0;
			if (q[0] == 8'h80) begin
				for (i = 1; i + 1 < q.size() && {q[i], q[i+1]} != 16'hffff; i = i + 2)
					exp.push_back({1'b1, q[i], q[i+1]});
			end else if (q[0] == 8'h81 || q[0] == 8'h82) begin
				k = (q[0] == 8'h81) ? 3 : 4;
				exp_short = q.size() < k;
				if (!exp_short) begin
					base = (k == 3) ? {1'b0, q[2], 7'h00} : {q[2], q[3]};
					for (i = k; i < q.size() && i - k < q[1]; i = i + 1)
						exp.push_back(q[i][7] ? {1'b1, base + q[i][6:0]} : {10'h000, q[i][6:0]});
					exp_short = i - k < q[1];
				end
			end else
				for (i = 0; i < q.size() && q[i] != 8'hff; i = i + 1)
					exp.push_back({10'h000, q[i][6:0]});
		end
	endtask
	task run;
		begin
			predict;
			for (i = 0; i < q.size(); i = i + 1) begin
				if ($random(seed) % 4 == 0) begin
					in_valid <= 1'b0;
					@(posedge clk);
				end
				in_valid <= 1'b1;
				in_byte <= q[i];
				in_last <= (i == q.size() - 1);
				do @(posedge clk); while (in_ready !== 1'b1);
			end
			in_valid <= 1'b0;
			for (w = 0; w < 300 && exp.size() != 0; w = w + 1)
				@(posedge clk);
			// let the record-end pulse be checked before the next prediction
			repeat (2) @(posedge clk);
			`CHK(exp.size(), 0)
		end
	endtask
	always @(posedge clk) begin
		if (resetn) begin
			if (out_valid === 1'b1 && out_ready === 1'b1) begin
				// an unexpected character meets an unknown and always mismatches
				want = 17'hx;
				if (exp.size() != 0)
					want = exp.pop_front();
				`CHK({out_ucs2, out_char}, want)
			end
			if (rec_done === 1'b1)
				`CHK(short_rec, exp_short)
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		q = '{8'h80, 8'h12, 8'h34, 8'hab, 8'hcd, 8'hff, 8'hff, 8'hff};
		run;
		q = '{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'ha6, 8'h41, 8'hff, 8'hff};
		run;
		q = '{8'h82, 8'h05, 8'h05, 8'h30, 8'h2d, 8'h82, 8'hd3, 8'h2d, 8'h31};
		run;
		q = '{8'h81, 8'h03};
		run;
		q = '{8'h80};
		run;
		q = '{8'h82};
		run;
		q = '{8'h82, 8'h00, 8'h12, 8'h34, 8'h55};
		run;
		q = '{8'h41, 8'h42, 8'hff, 8'h43};
		run;
		// base near the top wraps
		q = '{8'h82, 8'h02, 8'hff, 8'hf0, 8'hff, 8'h90, 8'h11};
		run;
		for (j = 0; j < 40; j = j + 1) begin
			slow <= j[0];
			t = $random(seed) & 3;
			q = '{(t == 0) ? 8'h80 : (t == 1) ? 8'h81 : (t == 2) ? 8'h82 : 8'($random(seed))};
			repeat ($random(seed) & 15) q.push_back(8'($random(seed)));
			run;
		end
		results;
	end
	initial begin
		#640000;
		n_mismatch = n_mismatch + 1;
		results;
	end
endmodule // tb
